// file: common/host_port_cfg.svh
// Constants for the two-channel host register port.
// Assumes inclusion by bare name from the package and the design files.
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

`define HP_ADDR_W        3
`define HP_DATA_W        8
`define HP_NUM_CHAN      2
`define HP_CHAN_A        1'h0
`define HP_CHAN_B        1'h1
`define HP_IRQ_OE_RST    1'h0
`define HP_AUX_IDLE      1'h1
`define HP_READY_IDLE    1'h1
`define HP_STROBE_IDLE   1'h1
`define HP_BUS_RELEASED  1'h1

`endif

// file: common/host_port_pkg.sv
// Types used by the host register port; its channel select helper uses only the constants header.
// Assumes the constants header is on the include path.
`default_nettype none
`include "host_port_cfg.svh"

package host_port_pkg;

    // One sampled view of the host bus pins.
    typedef struct packed {
        logic [`HP_ADDR_W-1:0] addr;
        logic [`HP_DATA_W-1:0] wdata;
        logic                  rd_n;
        logic                  wr_n;
        logic [`HP_NUM_CHAN-1:0] sel_n;
    } bus_pins_type;

    // One register access handed to a channel core.
    typedef struct packed {
        logic                  chan;
        logic [`HP_ADDR_W-1:0] addr;
        logic [`HP_DATA_W-1:0] data;
    } reg_access_type;

    // Phase of a host strobe cycle.
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_READ,
        PH_WRITE
    } phase_type;

endpackage
`default_nettype wire

// file: hw/chan_select.sv
// Decodes the active-low channel selects into a single valid channel index.
// Assumes selects are synchronous to the clock and at most one is low.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"

module chan_select (
    input  wire logic [`HP_NUM_CHAN-1:0] sel_n_i,
    output logic                         valid_o,
    output logic                         chan_o
);

    // A channel joins the transfer only while its select is low.
    always_comb begin
        valid_o = 1'h0;
        chan_o  = `HP_CHAN_A;
        if (!sel_n_i[0]) begin
            valid_o = 1'h1;
            chan_o  = `HP_CHAN_A;
        end else if (!sel_n_i[1]) begin
            valid_o = 1'h1;
            chan_o  = `HP_CHAN_B;
        end
    end

endmodule
`default_nettype wire

// file: hw/dual_uart_host_bus_port.sv
// Host parallel register port of a two-channel serial controller.
// Assumes bus pins are synchronous to clk_i and channel cores sit outside.
//
// How it works
// - Three address bits pick a register of the selected channel.
// - Eight-bit data bus: host drives writes, device drives reads.
// - Read strobe falling edge starts reading the addressed register.
// - Fetched byte stays on the bus until the read strobe rises.
// - Write strobe fall starts write; its rise loads bus data into register.
// - A channel is taken only if its select is low when the strobe falls.
// - Enable bit one: interrupt output driven, auxiliary output low.
// - Enable bit zero (reset): interrupt floats, auxiliary output high.
// - Each channel has an active-low transmit ready output.
// - Each channel has an active-low receive ready output.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"

module dual_uart_host_bus_port (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic [`HP_ADDR_W-1:0]        address_i,
    input  wire logic [`HP_DATA_W-1:0]        data_i,
    output logic      [`HP_DATA_W-1:0]        data_o,
    output logic                              data_oe_n_o,
    input  wire logic                         read_strobe_n_i,
    input  wire logic                         write_strobe_n_i,
    input  wire logic                         chan_a_select_n_i,
    input  wire logic                         chan_b_select_n_i,
    output logic                              rd_start_o,
    output logic                              rd_chan_o,
    output logic      [`HP_ADDR_W-1:0]        rd_addr_o,
    input  wire logic [`HP_DATA_W-1:0]        chan_a_rd_data_i,
    input  wire logic [`HP_DATA_W-1:0]        chan_b_rd_data_i,
    output logic                              wr_load_o,
    output logic                              wr_chan_o,
    output logic      [`HP_ADDR_W-1:0]        wr_addr_o,
    output logic      [`HP_DATA_W-1:0]        wr_data_o,
    input  wire logic [`HP_NUM_CHAN-1:0]      irq_output_enable_i,
    input  wire logic [`HP_NUM_CHAN-1:0]      irq_request_i,
    input  wire logic [`HP_NUM_CHAN-1:0]      tx_ready_i,
    input  wire logic [`HP_NUM_CHAN-1:0]      rx_ready_i,
    output logic                              chan_a_irq_out_o,
    output logic                              chan_a_irq_oe_n_o,
    output logic                              chan_b_irq_out_o,
    output logic                              chan_b_irq_oe_n_o,
    output logic                              chan_a_aux_out_n_o,
    output logic                              chan_b_aux_out_n_o,
    output logic                              chan_a_tx_ready_n_o,
    output logic                              chan_a_rx_ready_n_o,
    output logic                              chan_b_tx_ready_n_o,
    output logic                              chan_b_rx_ready_n_o
);

    //----------------------------------------------------------------
    // Channel decode
    //----------------------------------------------------------------

    host_port_pkg::bus_pins_type pins;
    logic                        sel_valid;
    logic                        sel_chan;

    // Bundle the pins for the strobe logic.
    assign pins = '{addr: address_i, wdata: data_i, rd_n: read_strobe_n_i,
                    wr_n: write_strobe_n_i,
                    sel_n: {chan_b_select_n_i, chan_a_select_n_i}};

    chan_select u_sel (
        .sel_n_i (pins.sel_n),
        .valid_o (sel_valid),
        .chan_o  (sel_chan)
    );

    //----------------------------------------------------------------
    // Strobe sequencer
    //----------------------------------------------------------------

    host_port_pkg::phase_type       phase_reg, phase_next;
    host_port_pkg::reg_access_type  acc_reg, acc_next;
    logic                           rd_prev_reg, rd_prev_next;
    logic                           wr_prev_reg, wr_prev_next;
    logic                           rd_start_reg, rd_start_next;
    logic                           wr_load_reg, wr_load_next;
    logic [`HP_DATA_W-1:0]          dout_reg, dout_next;
    logic                           doe_n_reg, doe_n_next;
    logic                           rd_fall;
    logic                           wr_fall;
    logic                           wr_rise;

    // Edges are seen against the strobe level of the previous cycle.
    assign rd_fall = rd_prev_reg && !pins.rd_n;
    assign wr_fall = wr_prev_reg && !pins.wr_n;
    assign wr_rise = !wr_prev_reg && pins.wr_n;

    // Next state of the strobe cycle, the access latch and the data driver.
    always_comb begin
        phase_next    = phase_reg;
        acc_next      = acc_reg;
        rd_prev_next  = pins.rd_n;
        wr_prev_next  = pins.wr_n;
        rd_start_next = 1'h0;
        wr_load_next  = 1'h0;
        dout_next     = dout_reg;
        doe_n_next    = doe_n_reg;
        unique case (phase_reg)
            host_port_pkg::PH_IDLE: begin
                doe_n_next = 1'h1;
                if (rd_fall && sel_valid) begin
                    phase_next    = host_port_pkg::PH_READ;
                    acc_next.chan = sel_chan;
                    acc_next.addr = pins.addr;
                    rd_start_next = 1'h1;
                end else if (wr_fall && sel_valid) begin
                    phase_next    = host_port_pkg::PH_WRITE;
                    acc_next.chan = sel_chan;
                    acc_next.addr = pins.addr;
                end
            end
            host_port_pkg::PH_READ: begin
                // Drive the fetched byte until the host lets the strobe rise.
                dout_next  = (acc_reg.chan == `HP_CHAN_B) ? chan_b_rd_data_i
                                                          : chan_a_rd_data_i;
                doe_n_next = 1'h0;
                if (pins.rd_n) begin
                    phase_next = host_port_pkg::PH_IDLE;
                    doe_n_next = 1'h1;
                end
            end
            host_port_pkg::PH_WRITE: begin
                doe_n_next = 1'h1;
                acc_next.data = pins.wdata;
                if (wr_rise) begin
                    phase_next    = host_port_pkg::PH_IDLE;
                    acc_next.data = pins.wdata;
                    wr_load_next  = 1'h1;
                end
            end
            default: begin
                phase_next = host_port_pkg::PH_IDLE;
            end
        endcase
    end

    // Register the sequencer state.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_reg    <= host_port_pkg::PH_IDLE;
            acc_reg      <= '0;
            rd_prev_reg  <= `HP_STROBE_IDLE;
            wr_prev_reg  <= `HP_STROBE_IDLE;
            rd_start_reg <= 1'h0;
            wr_load_reg  <= 1'h0;
            dout_reg     <= '0;
            doe_n_reg    <= `HP_BUS_RELEASED;
        end else begin
            phase_reg    <= phase_next;
            acc_reg      <= acc_next;
            rd_prev_reg  <= rd_prev_next;
            wr_prev_reg  <= wr_prev_next;
            rd_start_reg <= rd_start_next;
            wr_load_reg  <= wr_load_next;
            dout_reg     <= dout_next;
            doe_n_reg    <= doe_n_next;
        end
    end

    assign data_o      = dout_reg;
    assign data_oe_n_o = doe_n_reg;
    assign rd_start_o  = rd_start_reg;
    assign rd_chan_o   = acc_reg.chan;
    assign rd_addr_o   = acc_reg.addr;
    assign wr_load_o   = wr_load_reg;
    assign wr_chan_o   = acc_reg.chan;
    assign wr_addr_o   = acc_reg.addr;
    assign wr_data_o   = acc_reg.data;

    //----------------------------------------------------------------
    // Interrupt, auxiliary and ready pins
    //----------------------------------------------------------------

    logic [`HP_NUM_CHAN-1:0] irq_reg, irq_next;
    logic [`HP_NUM_CHAN-1:0] irq_oe_n_reg, irq_oe_n_next;
    logic [`HP_NUM_CHAN-1:0] aux_n_reg, aux_n_next;
    logic [`HP_NUM_CHAN-1:0] txr_n_reg, txr_n_next;
    logic [`HP_NUM_CHAN-1:0] rxr_n_reg, rxr_n_next;

    // Per channel pin state from the enable bit and the core status.
    for (genvar c = 0; c < `HP_NUM_CHAN; c++) begin : g_pins
        always_comb begin
            irq_next[c]      = irq_request_i[c];
            irq_oe_n_next[c] = !irq_output_enable_i[c];
            aux_n_next[c]    = !irq_output_enable_i[c];
            txr_n_next[c]    = !tx_ready_i[c];
            rxr_n_next[c]    = !rx_ready_i[c];
        end
    end

    // Register the pin state; reset leaves the interrupt floating.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_reg      <= '0;
            irq_oe_n_reg <= {`HP_NUM_CHAN{!`HP_IRQ_OE_RST}};
            aux_n_reg    <= {`HP_NUM_CHAN{`HP_AUX_IDLE}};
            txr_n_reg    <= {`HP_NUM_CHAN{`HP_READY_IDLE}};
            rxr_n_reg    <= {`HP_NUM_CHAN{`HP_READY_IDLE}};
        end else begin
            irq_reg      <= irq_next;
            irq_oe_n_reg <= irq_oe_n_next;
            aux_n_reg    <= aux_n_next;
            txr_n_reg    <= txr_n_next;
            rxr_n_reg    <= rxr_n_next;
        end
    end

    assign chan_a_irq_out_o    = irq_reg[0];
    assign chan_b_irq_out_o    = irq_reg[1];
    assign chan_a_irq_oe_n_o   = irq_oe_n_reg[0];
    assign chan_b_irq_oe_n_o   = irq_oe_n_reg[1];
    assign chan_a_aux_out_n_o  = aux_n_reg[0];
    assign chan_b_aux_out_n_o  = aux_n_reg[1];
    assign chan_a_tx_ready_n_o = txr_n_reg[0];
    assign chan_b_tx_ready_n_o = txr_n_reg[1];
    assign chan_a_rx_ready_n_o = rxr_n_reg[0];
    assign chan_b_rx_ready_n_o = rxr_n_reg[1];

    //----------------------------------------------------------------
    // Checks
    //----------------------------------------------------------------

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_rd_open;
        phase_reg == host_port_pkg::PH_IDLE && rd_fall && sel_valid;
    endsequence

    a_read_start_pulse: assert property (s_rd_open |=> rd_start_o)
        else $error("read start missing");
    a_read_addr_latch: assert property (s_rd_open |=> rd_addr_o == $past(address_i))
        else $error("read address not latched");
    a_read_drive_bus: assert property (s_rd_open ##1 !read_strobe_n_i |=> !data_oe_n_o)
        else $error("read data not driven");
    a_read_release_bus: assert property (phase_reg == host_port_pkg::PH_READ
        && read_strobe_n_i |=> data_oe_n_o [*2])
        else $error("bus not released after read");
    a_write_load_data: assert property (phase_reg == host_port_pkg::PH_WRITE && wr_rise
        |=> wr_load_o && wr_data_o == $past(data_i))
        else $error("write data not loaded");
    a_no_select_idle: assert property (phase_reg == host_port_pkg::PH_IDLE && !sel_valid
        |=> !rd_start_o && phase_reg == host_port_pkg::PH_IDLE)
        else $error("unselected access taken");
    a_irq_enable_pins: assert property (irq_output_enable_i[0]
        |=> !chan_a_irq_oe_n_o && !chan_a_aux_out_n_o)
        else $error("interrupt enable pins wrong");
    a_irq_float_pins: assert property (!irq_output_enable_i[1]
        |=> chan_b_irq_oe_n_o && chan_b_aux_out_n_o)
        else $error("interrupt float pins wrong");
    a_tx_ready_pin: assert property (tx_ready_i[0] |=> !chan_a_tx_ready_n_o)
        else $error("transmit ready wrong");
    a_rx_ready_pin: assert property (rx_ready_i[1] |=> !chan_b_rx_ready_n_o)
        else $error("receive ready wrong");

endmodule
`default_nettype wire

// file: verification/host_model.sv
// Host processor model that drives the two-channel register port.
// Assumes the port answers a read by lowering its data enable within a few cycles.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"

module host_model (
    input  wire logic                  clk_i,
    output logic [`HP_ADDR_W-1:0]      address_o,
    output logic [`HP_DATA_W-1:0]      bus_o,
    output logic                       read_strobe_n_o,
    output logic                       write_strobe_n_o,
    output logic                       chan_a_select_n_o,
    output logic                       chan_b_select_n_o,
    input  wire logic [`HP_DATA_W-1:0] dev_data_i,
    input  wire logic                  dev_oe_n_i
);
    logic [`HP_DATA_W-1:0] host_data;
    logic                  host_drive;
    logic [`HP_DATA_W-1:0] float_reg;

    // The wire carries the device byte, the host byte, or a toggling pattern when released.
    assign bus_o = !dev_oe_n_i ? dev_data_i : (host_drive ? host_data : float_reg);

    // A released wire keeps no value, so it flips every cycle.
    always @(posedge clk_i) begin
        float_reg <= ~bus_o;
    end

    // Bus idles with both strobes and both selects high.
    initial begin
        address_o = 3'h0;
        read_strobe_n_o = 1'h1;
        write_strobe_n_o = 1'h1;
        chan_a_select_n_o = 1'h1;
        chan_b_select_n_o = 1'h1;
        host_data = 8'h00;
        host_drive = 1'h0;
        float_reg = 8'h5a;
    end

    // One strobe cycle; address and the single select hold until after the strobe rises.
    task automatic do_cycle(input use_sel, input chan, input [2:0] addr,
                            input rd, input [7:0] wdata,
                            output [7:0] rdata, output ok);
        int n;
        rdata = 8'h00;
        ok = !rd;
        @(posedge clk_i);
        address_o <= addr;
        chan_a_select_n_o <= !(use_sel && chan == `HP_CHAN_A);
        chan_b_select_n_o <= !(use_sel && chan == `HP_CHAN_B);
        read_strobe_n_o <= !rd;
        write_strobe_n_o <= rd;
        host_data <= wdata;
        host_drive <= !rd;
        for (n = 0; n < 12 && !ok; n++) begin
            @(negedge clk_i);
            if (dev_oe_n_i === 1'h0) begin
                ok = 1'h1;
                rdata = bus_o;
            end
        end
        if (!rd) begin
            repeat (2) @(posedge clk_i);
        end
        @(posedge clk_i);
        read_strobe_n_o <= 1'h1;
        write_strobe_n_o <= 1'h1;
        @(posedge clk_i);
        chan_a_select_n_o <= 1'h1;
        chan_b_select_n_o <= 1'h1;
        host_drive <= 1'h0;
    endtask
endmodule
`default_nettype wire

// file: verification/tb_dual_uart_host_bus_port.sv
// Self-checking bench for the two-channel host register port.
// Assumes the host model and a simple core model stand around the port.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"

module tb_dual_uart_host_bus_port;
    logic       clk_i, rst_i, read_strobe_n_i, write_strobe_n_i, data_oe_n_o;
    logic       chan_a_select_n_i, chan_b_select_n_i, rd_start_o, rd_chan_o;
    logic       wr_load_o, wr_chan_o, chan_a_irq_out_o, chan_a_irq_oe_n_o;
    logic       chan_b_irq_out_o, chan_b_irq_oe_n_o, chan_a_aux_out_n_o, chan_b_aux_out_n_o;
    logic       chan_a_tx_ready_n_o, chan_a_rx_ready_n_o, chan_b_tx_ready_n_o, chan_b_rx_ready_n_o;
    logic [2:0] address_i, rd_addr_o, wr_addr_o;
    logic [7:0] data_i, data_o, chan_a_rd_data_i, chan_b_rd_data_i, wr_data_o;
    logic [1:0] irq_output_enable_i, irq_request_i, tx_ready_i, rx_ready_i;
    logic [11:0] rd_seen, wr_seen;
    int         rd_cnt = 0, wr_cnt = 0, bad_count = 0, total_checks = 0;

    dual_uart_host_bus_port DUT (.clk_i, .rst_i, .address_i, .data_i, .data_o, .data_oe_n_o,
        .read_strobe_n_i, .write_strobe_n_i, .chan_a_select_n_i, .chan_b_select_n_i,
        .rd_start_o, .rd_chan_o, .rd_addr_o, .chan_a_rd_data_i, .chan_b_rd_data_i,
        .wr_load_o, .wr_chan_o, .wr_addr_o, .wr_data_o, .irq_output_enable_i, .irq_request_i,
        .tx_ready_i, .rx_ready_i, .chan_a_irq_out_o, .chan_a_irq_oe_n_o, .chan_b_irq_out_o,
        .chan_b_irq_oe_n_o, .chan_a_aux_out_n_o, .chan_b_aux_out_n_o, .chan_a_tx_ready_n_o,
        .chan_a_rx_ready_n_o, .chan_b_tx_ready_n_o, .chan_b_rx_ready_n_o);

    host_model host (.clk_i, .address_o(address_i), .bus_o(data_i),
        .read_strobe_n_o(read_strobe_n_i), .write_strobe_n_o(write_strobe_n_i),
        .chan_a_select_n_o(chan_a_select_n_i), .chan_b_select_n_o(chan_b_select_n_i),
        .dev_data_i(data_o), .dev_oe_n_i(data_oe_n_o));

    // Channel cores return a byte that encodes channel and register address.
    assign chan_a_rd_data_i = {5'h14, rd_addr_o};
    assign chan_b_rd_data_i = {5'h0a, rd_addr_o};

    // Clock at 5 ns and the counters of read starts and write loads.
    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (rd_start_o === 1'h1) begin
            rd_cnt <= rd_cnt + 1;
            rd_seen <= {8'h00, rd_chan_o, rd_addr_o};
        end
        if (wr_load_o === 1'h1) begin
            wr_cnt <= wr_cnt + 1;
            wr_seen <= {wr_chan_o, wr_addr_o, wr_data_o};
        end
    end

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic check_val(input string name, input [11:0] exp, input [11:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic pin_status_of(output logic [11:0] v);
        v = {4'h0, chan_a_irq_oe_n_o, chan_b_irq_oe_n_o, chan_a_aux_out_n_o, chan_b_aux_out_n_o,
             chan_a_tx_ready_n_o, chan_a_rx_ready_n_o, chan_b_tx_ready_n_o, chan_b_rx_ready_n_o};
    endtask

    task automatic test_reset();
        logic [11:0] v;
        pin_status_of(v);
        check_val("idle pins", 12'h0ff, v);
        check_val("data enable", 12'h001, {11'h000, data_oe_n_o});
    endtask

    task automatic test_reads();
        logic [7:0] d;
        logic       ok;
        int         c0;
        for (int k = 0; k < 16; k++) begin
            c0 = rd_cnt;
            host.do_cycle(1'h1, k[3], k[2:0], 1'h1, 8'h00, d, ok);
            check_val("read answered", 12'h001, {11'h000, ok});
            check_val("read byte", {4'h0, k[3] ? 5'h0a : 5'h14, k[2:0]}, {4'h0, d});
            repeat (3) @(negedge clk_i);
            check_val("read starts", 12'h001, 12'(rd_cnt - c0));
            check_val("read target", {8'h00, k[3:0]}, rd_seen);
            check_val("bus released", 12'h001, {11'h000, data_oe_n_o});
        end
    endtask

    task automatic test_writes();
        logic [7:0] d;
        logic       ok;
        int         c0;
        for (int k = 0; k < 16; k++) begin
            c0 = wr_cnt;
            host.do_cycle(1'h1, k[3], k[2:0], 1'h0, {k[3], 4'h9, k[2:0]}, d, ok);
            repeat (4) @(negedge clk_i);
            check_val("write loads", 12'h001, 12'(wr_cnt - c0));
            check_val("write target", {k[3:0], k[3], 4'h9, k[2:0]}, wr_seen);
        end
    endtask

    task automatic test_refused();
        logic [7:0] d;
        logic       ok;
        int         r0, w0;
        r0 = rd_cnt;
        w0 = wr_cnt;
        host.do_cycle(1'h0, 1'h0, 3'h3, 1'h1, 8'h00, d, ok);
        check_val("unselected read", 12'h000, {11'h000, ok});
        host.do_cycle(1'h0, 1'h0, 3'h5, 1'h0, 8'hff, d, ok);
        repeat (4) @(negedge clk_i);
        check_val("unselected pulses", 12'h000, 12'(rd_cnt - r0 + wr_cnt - w0));
    endtask

    task automatic test_pins();
        logic [11:0] v;
        logic [1:0]  en;
        for (int k = 0; k < 8; k++) begin
            en = k[1:0];
            @(posedge clk_i);
            irq_output_enable_i <= en;
            irq_request_i <= {k[2], ~k[2]};
            tx_ready_i <= en ^ 2'h1;
            rx_ready_i <= ~en;
            repeat (2) @(negedge clk_i);
            pin_status_of(v);
            check_val("status pins", {4'h0, ~en[0], ~en[1], ~en[0], ~en[1], en[0] ^ 1'h0,
                en[0], ~en[1], en[1]}, v);
            check_val("irq value", {10'h000, {k[2], ~k[2]} & en}, {10'h000,
                chan_b_irq_out_o & !chan_b_irq_oe_n_o, chan_a_irq_out_o & !chan_a_irq_oe_n_o});
        end
    endtask

    // Watchdog cuts a hang short well beyond the expected run of about 290 cycles.
    initial begin
        #(4000 * 5);
        bad_count++;
        $display("[FAIL] watchdog expected finish seen hang");
        wrap_up();
    end

    // Reset for 8 cycles, then the scenarios in turn.
    initial begin
        rst_i = 1'h1;
        irq_output_enable_i = 2'h0;
        irq_request_i = 2'h0;
        tx_ready_i = 2'h0;
        rx_ready_i = 2'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (2) @(negedge clk_i);
        test_reset();
        test_reads();
        test_writes();
        test_refused();
        test_pins();
        wrap_up();
    end
endmodule
`default_nettype wire
